/* core/pmic_top.sv */
//
// ------------------------------------------------------------
// command input logic for position control mode
// ------------------------------------------------------------
//
// Design decisions made here: the register addresses and the address-and-strobe port.
module pmic_top
    import pmic_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  reset,
    // register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [31:0]           reg_rdata,
    // command pins, active high
    input  wire logic [NUM_SELECT-1:0] direct_select_inputs,
    input  wire logic                  jog_positive_input,
    input  wire logic                  jog_negative_input,
    input  wire logic                  preset_input,
    // motor state from the drive core, same clock
    input  wire logic                  alarm_present,
    input  wire logic                  motor_operating,
    input  wire logic                  ready_raw,
    input  wire logic                  home_raw,
    input  wire logic                  end_raw,
    input  wire logic                  torque_reached_raw,
    input  wire logic                  torque_limiting_raw,
    // command to the drive core
    output logic                       start_pulse,
    output logic [1:0]                 start_kind,
    output logic [DATA_NUM_W-1:0]      start_data_num,
    output logic [SPEED_W-1:0]         start_speed,
    output logic [ACCEL_W-1:0]         start_accel,
    output logic [TORQUE_W-1:0]        start_torque,
    output logic [POS_W-1:0]           start_travel,
    output logic [POS_W-1:0]           command_position,
    // mode-gated output signals
    output logic                       ready_output,
    output logic                       home_output,
    output logic                       end_output,
    output logic                       torque_limit_reached_output,
    output logic                       torque_limiting_output
);

    // ------------------------------------------------------------
    // settings
    // ------------------------------------------------------------
    logic [NUM_SELECT*DATA_NUM_W-1:0] select_map;
    logic [SPEED_W-1:0]               jog_speed;
    logic [ACCEL_W-1:0]               jog_accel;
    logic [TORQUE_W-1:0]              jog_torque;
    logic [TRAVEL_W-1:0]              jog_travel;
    logic [POS_W-1:0]                 preset_value;
    logic                             position_mode;
    logic                             compatible_mode;

    pmic_regs u_regs (
        .mclk            (mclk),
        .reset           (reset),
        .reg_addr        (reg_addr),
        .reg_wdata       (reg_wdata),
        .reg_write       (reg_write),
        .select_map      (select_map),
        .jog_speed       (jog_speed),
        .jog_accel       (jog_accel),
        .jog_torque      (jog_torque),
        .jog_travel      (jog_travel),
        .preset_value    (preset_value),
        .position_mode   (position_mode),
        .compatible_mode (compatible_mode)
    );

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    localparam int NUM_PINS = NUM_SELECT + 3;

    logic [NUM_PINS-1:0] pin_level;
    logic [NUM_PINS-1:0] pin_rise;

    pmic_sync #(
        .WIDTH (NUM_PINS)
    ) u_sync (
        .mclk  (mclk),
        .reset (reset),
        .pin   ({preset_input, jog_negative_input, jog_positive_input, direct_select_inputs}),
        .level (pin_level),
        .rise  (pin_rise)
    );

    logic [NUM_SELECT-1:0] select_rise;
    logic                  jog_pos_rise;
    logic                  jog_neg_rise;
    logic                  preset_rise;

    assign select_rise  = pin_rise[NUM_SELECT-1:0];
    assign jog_pos_rise = pin_rise[NUM_SELECT];
    assign jog_neg_rise = pin_rise[NUM_SELECT+1];
    assign preset_rise  = pin_rise[NUM_SELECT+2];

    // ------------------------------------------------------------
    // command arbitration
    // ------------------------------------------------------------
    pmic_cmd_t             next_kind;
    logic [DATA_NUM_W-1:0] next_data_num;

    // lowest direct input wins, then positive jog, then negative jog
    always_comb begin
        next_kind     = PMIC_CMD_NONE;
        next_data_num = '0;
        if (position_mode) begin
            if (|select_rise) begin
                next_kind = PMIC_CMD_DIRECT;
                for (int i = NUM_SELECT - 1; i >= 0; i--) begin
                    if (select_rise[i]) begin
                        next_data_num = select_map[i*DATA_NUM_W +: DATA_NUM_W];
                    end
                end
            end else if (jog_pos_rise) begin
                next_kind = PMIC_CMD_JOG_POS;
            end else if (jog_neg_rise) begin
                next_kind = PMIC_CMD_JOG_NEG;
            end
        end
    end

    // one start pulse per accepted edge
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            start_pulse    <= 1'b0;
            start_kind     <= PMIC_CMD_NONE;
            start_data_num <= '0;
            start_speed    <= '0;
            start_accel    <= '0;
            start_torque   <= '0;
            start_travel   <= '0;
        end else begin
            start_pulse <= (next_kind != PMIC_CMD_NONE);
            if (next_kind != PMIC_CMD_NONE) begin
                start_kind     <= next_kind;
                start_data_num <= next_data_num;
                start_speed    <= jog_speed;
                start_accel    <= jog_accel;
                start_torque   <= jog_torque;
                if (next_kind == PMIC_CMD_JOG_NEG) begin
                    start_travel <= POS_W'(-$signed({1'b0, jog_travel}));
                end else begin
                    start_travel <= {1'b0, jog_travel};
                end
            end
        end
    end

    // ------------------------------------------------------------
    // position preset
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            command_position <= PRESET_RESET;
        end else if (position_mode && preset_rise
                     && !alarm_present && !motor_operating) begin
            command_position <= preset_value;
        end
    end

    // ------------------------------------------------------------
    // mode-gated outputs
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            ready_output                <= 1'b0;
            home_output                 <= 1'b0;
            end_output                  <= 1'b0;
            torque_limit_reached_output <= 1'b0;
            torque_limiting_output      <= 1'b0;
        end else begin
            ready_output                <= position_mode & ready_raw;
            home_output                 <= position_mode & home_raw;
            end_output                  <= position_mode & end_raw;
            torque_limit_reached_output <= ~compatible_mode & torque_reached_raw;
            torque_limiting_output      <= compatible_mode & torque_limiting_raw;
        end
    end

    // ------------------------------------------------------------
    // register read back
    // ------------------------------------------------------------
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            reg_rdata <= '0;
        end else if (reg_read) begin
            unique case (reg_addr)
                REG_SELECT_MAP: reg_rdata <= 32'(select_map);
                REG_JOG_SPEED:  reg_rdata <= 32'(jog_speed);
                REG_JOG_ACCEL:  reg_rdata <= 32'(jog_accel);
                REG_JOG_TORQUE: reg_rdata <= 32'(jog_torque);
                REG_JOG_TRAVEL: reg_rdata <= 32'(jog_travel);
                REG_PRESET:     reg_rdata <= 32'(preset_value);
                REG_MODE:       reg_rdata <= {30'h0, compatible_mode, position_mode};
                REG_STATUS:     reg_rdata <= 32'({motor_operating, alarm_present, pin_level});
                REG_POSITION:   reg_rdata <= 32'(command_position);
                default:        reg_rdata <= '0;
            endcase
        end else begin
            reg_rdata <= '0;
        end
    end

endmodule

/* core/pmic_pkg.sv */
package pmic_pkg;

    // ------------------------------------------------------------
    // geometry
    // ------------------------------------------------------------
    localparam int NUM_SELECT    = 6;
    localparam int DATA_NUM_W    = 4;
    localparam int SPEED_W       = 12;
    localparam int ACCEL_W       = 15;
    localparam int TORQUE_W      = 8;
    localparam int TRAVEL_W      = 23;
    localparam int POS_W         = 24;

    // ------------------------------------------------------------
    // settings after reset and their limits
    // ------------------------------------------------------------
    localparam logic [SPEED_W-1:0]  JOG_SPEED_RESET  = 12'h12C; // 300 r/min
    localparam logic [SPEED_W-1:0]  JOG_SPEED_MAX    = 12'hFA0; // 4000 r/min
    localparam logic [ACCEL_W-1:0]  JOG_ACCEL_RESET  = 15'h0064; // 0.100 s in ms
    localparam logic [ACCEL_W-1:0]  JOG_ACCEL_MAX    = 15'h7530; // 30.000 s in ms
    localparam logic [TORQUE_W-1:0] JOG_TORQUE_RESET = 8'h64;   // 100 percent
    localparam logic [TORQUE_W-1:0] JOG_TORQUE_MAX   = 8'hFA;   // 250 percent
    localparam logic [TRAVEL_W-1:0] JOG_TRAVEL_RESET = 23'h000001;
    localparam logic [TRAVEL_W-1:0] JOG_TRAVEL_MIN   = 23'h000001;
    localparam logic [POS_W-1:0]    PRESET_RESET     = 24'h000000;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [3:0] REG_SELECT_MAP = 4'h0; // six 4-bit fields
    localparam logic [3:0] REG_JOG_SPEED  = 4'h1;
    localparam logic [3:0] REG_JOG_ACCEL  = 4'h2;
    localparam logic [3:0] REG_JOG_TORQUE = 4'h3;
    localparam logic [3:0] REG_JOG_TRAVEL = 4'h4;
    localparam logic [3:0] REG_PRESET     = 4'h5;
    localparam logic [3:0] REG_MODE       = 4'h6; // bit0 position, bit1 compatible
    localparam logic [3:0] REG_STATUS     = 4'h7;
    localparam logic [3:0] REG_POSITION   = 4'h8;

    // ------------------------------------------------------------
    // command kinds
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PMIC_CMD_NONE    = 2'b00,
        PMIC_CMD_DIRECT  = 2'b01,
        PMIC_CMD_JOG_POS = 2'b10,
        PMIC_CMD_JOG_NEG = 2'b11
    } pmic_cmd_t;

endpackage

/* core/pmic_sync.sv */
module pmic_sync
    import pmic_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             reset,
    // pins in, synchronised level and rising edge out
    input  wire logic [WIDTH-1:0] pin,
    output logic      [WIDTH-1:0] level,
    output logic      [WIDTH-1:0] rise
);

    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;

    // two-flop synchroniser; stage1 feeds stage2 only
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            stage1 <= '0;
            stage2 <= '0;
        end else begin
            stage1 <= pin;
            stage2 <= stage1;
        end
    end

    // edge detect after synchronisation
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            level <= '0;
        end else begin
            level <= stage2;
        end
    end

    assign rise = stage2 & ~level;

endmodule

/* core/pmic_regs.sv */
module pmic_regs
    import pmic_pkg::*;
(
    // clock and reset
    input  wire logic                       mclk,
    input  wire logic                       reset,
    // register port
    input  wire logic [3:0]                 reg_addr,
    input  wire logic [31:0]                reg_wdata,
    input  wire logic                       reg_write,
    // settings out
    output logic [NUM_SELECT*DATA_NUM_W-1:0] select_map,
    output logic [SPEED_W-1:0]              jog_speed,
    output logic [ACCEL_W-1:0]              jog_accel,
    output logic [TORQUE_W-1:0]             jog_torque,
    output logic [TRAVEL_W-1:0]             jog_travel,
    output logic [POS_W-1:0]                preset_value,
    output logic                            position_mode,
    output logic                            compatible_mode
);

    // default map 0..5 in input order
    function automatic logic [NUM_SELECT*DATA_NUM_W-1:0] map_reset();
        logic [NUM_SELECT*DATA_NUM_W-1:0] m;
        m = '0;
        for (int i = 0; i < NUM_SELECT; i++) begin
            m[i*DATA_NUM_W +: DATA_NUM_W] = DATA_NUM_W'(i);
        end
        return m;
    endfunction

    // settings writes, out-of-range values are clamped
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            select_map      <= map_reset();
            jog_speed       <= JOG_SPEED_RESET;
            jog_accel       <= JOG_ACCEL_RESET;
            jog_torque      <= JOG_TORQUE_RESET;
            jog_travel      <= JOG_TRAVEL_RESET;
            preset_value    <= PRESET_RESET;
            position_mode   <= 1'b1;
            compatible_mode <= 1'b0;
        end else if (reg_write) begin
            unique case (reg_addr)
                REG_SELECT_MAP: select_map <= reg_wdata[NUM_SELECT*DATA_NUM_W-1:0];
                REG_JOG_SPEED: begin
                    if (reg_wdata[SPEED_W-1:0] > JOG_SPEED_MAX) begin
                        jog_speed <= JOG_SPEED_MAX;
                    end else begin
                        jog_speed <= reg_wdata[SPEED_W-1:0];
                    end
                end
                REG_JOG_ACCEL: begin
                    if (reg_wdata[ACCEL_W-1:0] > JOG_ACCEL_MAX) begin
                        jog_accel <= JOG_ACCEL_MAX;
                    end else begin
                        jog_accel <= reg_wdata[ACCEL_W-1:0];
                    end
                end
                REG_JOG_TORQUE: begin
                    if (reg_wdata[TORQUE_W-1:0] > JOG_TORQUE_MAX) begin
                        jog_torque <= JOG_TORQUE_MAX;
                    end else begin
                        jog_torque <= reg_wdata[TORQUE_W-1:0];
                    end
                end
                REG_JOG_TRAVEL: begin
                    if (reg_wdata[TRAVEL_W-1:0] < JOG_TRAVEL_MIN) begin
                        jog_travel <= JOG_TRAVEL_MIN;
                    end else begin
                        jog_travel <= reg_wdata[TRAVEL_W-1:0];
                    end
                end
                REG_PRESET: preset_value <= reg_wdata[POS_W-1:0];
                REG_MODE: begin
                    position_mode   <= reg_wdata[0];
                    compatible_mode <= reg_wdata[1];
                end
                default: ;
            endcase
        end
    end

endmodule

/* test/pmic_properties.sv */
module pmic_properties
    import pmic_pkg::*;
(
    // clock and reset
    input wire logic                  mclk,
    input wire logic                  reset,
    // register port
    input wire logic [3:0]            reg_addr,
    input wire logic [31:0]           reg_wdata,
    input wire logic                  reg_write,
    input wire logic                  reg_read,
    input wire logic [31:0]           reg_rdata,
    // command pins and motor state
    input wire logic [NUM_SELECT-1:0] direct_select_inputs,
    input wire logic                  jog_positive_input,
    input wire logic                  jog_negative_input,
    input wire logic                  preset_input,
    input wire logic                  alarm_present,
    input wire logic                  motor_operating,
    input wire logic                  ready_raw,
    // command and gated outputs
    input wire logic                  start_pulse,
    input wire logic [1:0]            start_kind,
    input wire logic [DATA_NUM_W-1:0] start_data_num,
    input wire logic [POS_W-1:0]      start_travel,
    input wire logic [POS_W-1:0]      command_position,
    input wire logic                  ready_output,
    input wire logic                  torque_limit_reached_output
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [8:0]            prev;
    logic [8:0]            rise;
    logic [23:0]           map;
    logic [POS_W-1:0]      preset;
    logic                  pos_mode;
    logic                  compat;
    logic [DATA_NUM_W-1:0] exp_num;

    // pin levels one cycle back, for edge detection
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) prev <= '0;
        else prev <= {preset_input, jog_negative_input, jog_positive_input, direct_select_inputs};
    end
    assign rise = {preset_input, jog_negative_input, jog_positive_input, direct_select_inputs}
                  & ~prev;

    // shadow of the map, preset and mode settings written over the register port
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            map      <= 24'h543210;
            preset   <= '0;
            pos_mode <= 1'b1;
            compat   <= 1'b0;
        end else if (reg_write) begin
            if (reg_addr == REG_SELECT_MAP) map <= reg_wdata[23:0];
            if (reg_addr == REG_PRESET) preset <= reg_wdata[23:0];
            if (reg_addr == REG_MODE) {compat, pos_mode} <= reg_wdata[1:0];
        end
    end

    // data number of the lowest rising select input
    always_comb begin
        exp_num = '0;
        for (int i = NUM_SELECT - 1; i >= 0; i--) begin
            if (rise[i]) exp_num = map[4*i +: 4];
        end
    end

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    a_direct_start:
        assert property (|rise[5:0] && pos_mode |-> ##3 start_pulse && start_kind == 2'h1
                         && start_data_num == $past(exp_num, 3)) else $error("bad direct start");
    a_jog_positive:
        assert property (rise[6] && !(|rise[5:0]) && pos_mode |-> ##3 start_pulse
                         && start_kind == 2'h2 && !start_travel[23]) else $error("bad jog+");
    a_jog_negative:
        assert property (rise[7] && !(|rise[6:0]) && pos_mode |-> ##3 start_pulse
                         && start_kind == 2'h3 && start_travel[23]) else $error("bad jog-");
    a_mode_gate:
        assert property (start_pulse |-> $past(pos_mode, 1)) else $error("start outside mode");
    a_single_start:
        assert property (start_pulse |=> !start_pulse [*8]) else $error("repeated start");
    a_preset_load:
        assert property (rise[8] && pos_mode && !alarm_present && !motor_operating
                         |-> ##3 command_position == $past(preset, 3)) else $error("no preset");
    a_preset_block:
        assert property (rise[8] && (alarm_present || motor_operating)
                         |=> $stable(command_position) [*5]) else $error("preset not blocked");
    a_ready_follow:
        assert property (ready_raw && pos_mode |=> ready_output) else $error("ready lost");
    a_ready_quiet:
        assert property (!pos_mode |=> !ready_output) else $error("ready outside mode");
    a_torque_split:
        assert property (compat |=> !torque_limit_reached_output) else $error("reached in compat");
    a_rdata_idle:
        assert property (!reg_read |=> reg_rdata == 32'h0) else $error("read data not idle");

    c_direct: cover property (start_pulse && start_kind == 2'h1);
    c_jog_neg: cover property (start_pulse && start_kind == 2'h3);
    c_blocked: cover property (rise[8] && alarm_present);
endmodule

bind pmic_top pmic_properties u_chk (
    .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .direct_select_inputs(direct_select_inputs), .jog_positive_input(jog_positive_input),
    .jog_negative_input(jog_negative_input), .preset_input(preset_input),
    .alarm_present(alarm_present), .motor_operating(motor_operating), .ready_raw(ready_raw),
    .start_pulse(start_pulse), .start_kind(start_kind), .start_data_num(start_data_num),
    .start_travel(start_travel), .command_position(command_position),
    .ready_output(ready_output), .torque_limit_reached_output(torque_limit_reached_output)
);

/* test/pmic_host.sv */
module pmic_host (
    // clock and bench request
    input  wire logic       mclk,
    input  wire logic [8:0] req,
    // pins: six direct, jog+, jog-, preset
    output logic      [8:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;

    initial pins = 9'h000;

    // controller answers one cycle after being asked, holds while asked
    always @(posedge mclk) begin
        pins <= req;
    end
endmodule

/* test/tb.sv */
module tb
    import pmic_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic mclk = 1'b0, reset = 1'b1, reg_write = 1'b0, reg_read = 1'b0;
    logic alarm_present = 1'b0, motor_operating = 1'b0;
    logic ready_raw = 1'b0, home_raw = 1'b0, end_raw = 1'b0;
    logic torque_reached_raw = 1'b0, torque_limiting_raw = 1'b0;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0, reg_rdata;
    logic [8:0] req = 9'h000, pins;
    logic start_pulse, ready_output, home_output, end_output;
    logic torque_limit_reached_output, torque_limiting_output;
    logic [1:0] start_kind;
    logic [DATA_NUM_W-1:0] start_data_num;
    logic [SPEED_W-1:0] start_speed;
    logic [ACCEL_W-1:0] start_accel;
    logic [TORQUE_W-1:0] start_torque;
    logic [POS_W-1:0] start_travel, command_position;
    int n_mismatch = 0, n_tests = 0;
    localparam logic [3:0] ADR [4] = '{REG_JOG_SPEED, REG_JOG_ACCEL, REG_JOG_TORQUE,
                                       REG_JOG_TRAVEL};
    localparam logic [31:0] CORNER [4] = '{32'hFA1, 32'h7531, 32'hFB, 32'h0};
    localparam logic [31:0] MASK [4] = '{32'hFFF, 32'h7FFF, 32'hFF, 32'h7FFFFF};

    always #2 mclk = ~mclk;

    pmic_host host (.mclk(mclk), .req(req), .pins(pins));

    pmic_top dut (
        .mclk(mclk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .direct_select_inputs(pins[5:0]), .jog_positive_input(pins[6]),
        .jog_negative_input(pins[7]), .preset_input(pins[8]),
        .alarm_present(alarm_present), .motor_operating(motor_operating),
        .ready_raw(ready_raw), .home_raw(home_raw), .end_raw(end_raw),
        .torque_reached_raw(torque_reached_raw), .torque_limiting_raw(torque_limiting_raw),
        .start_pulse(start_pulse), .start_kind(start_kind), .start_data_num(start_data_num),
        .start_speed(start_speed), .start_accel(start_accel), .start_torque(start_torque),
        .start_travel(start_travel), .command_position(command_position),
        .ready_output(ready_output), .home_output(home_output), .end_output(end_output),
        .torque_limit_reached_output(torque_limit_reached_output),
        .torque_limiting_output(torque_limiting_output)
    );

    // compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // register write and read, one strobe cycle each
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge mclk);
        reg_write <= 1'b0;
    endtask

    task automatic rchk(input logic [3:0] a, input logic [31:0] exp);
        @(posedge mclk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge mclk);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // raise pins, wait for a start (kind 0: none expected), hold, release
    task automatic go(input logic [8:0] m, input logic [1:0] k, input logic [3:0] num);
        @(posedge mclk);
        req <= m;
        for (int i = 0; i < 10 && start_pulse !== 1'b1; i++) begin
            @(posedge mclk);
            #1;
        end
        chk(32'(start_pulse), 32'(k != 2'h0));
        if (k != 2'h0) chk(32'(start_kind), 32'(k));
        if (k == 2'h1) chk(32'(start_data_num), 32'(num));
        repeat (12) @(posedge mclk);
        req <= 9'h000;
        repeat (4) @(posedge mclk);
    endtask

    // readback of a clamped setting
    function automatic logic [31:0] lim(input logic [3:0] a, input logic [31:0] v);
        logic [31:0] m;
        m = (a == REG_JOG_SPEED) ? 32'(JOG_SPEED_MAX) :
            (a == REG_JOG_ACCEL) ? 32'(JOG_ACCEL_MAX) : 32'(JOG_TORQUE_MAX);
        if (a == REG_JOG_TRAVEL) return (v == 32'h0) ? 32'h1 : v;
        return (v > m) ? m : v;
    endfunction

    // gated outputs: ready, home, end, reached, limiting
    function automatic logic [4:0] outx(input logic [4:0] r, input logic [1:0] md);
        return r & {{3{md[0]}}, ~md[1], md[1]};
    endfunction

    task automatic conclude();
        $display("mismatches %0d, comparisons %0d", n_mismatch, n_tests);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // watchdog
    initial begin
        repeat (20000) @(posedge mclk);
        n_mismatch++;
        $display("ERROR %0t: timeout", $time);
        conclude();
    end

    initial begin
        logic [31:0] jx [4];
        logic [31:0] v;
        logic [23:0] map, pv;
        logic [4:0] r;
        void'($urandom(94069));
        repeat (16) @(posedge mclk);
        reset <= 1'b0;
        // settings after reset, unmapped offsets
        rchk(REG_SELECT_MAP, 32'h00543210);
        rchk(REG_JOG_SPEED, 32'(JOG_SPEED_RESET));
        rchk(REG_JOG_ACCEL, 32'(JOG_ACCEL_RESET));
        rchk(REG_JOG_TORQUE, 32'(JOG_TORQUE_RESET));
        rchk(REG_JOG_TRAVEL, 32'h1);
        rchk(REG_PRESET, 32'h0);
        for (int a = 9; a < 16; a++) rchk(4'(a), 32'h0);
        // jog settings: limits, then random values
        for (int i = 0; i < 12; i++) begin
            v = (i < 4) ? CORNER[i] : ($urandom & MASK[i % 4]);
            jx[i % 4] = lim(ADR[i % 4], v);
            wr(ADR[i % 4], v);
            rchk(ADR[i % 4], jx[i % 4]);
        end
        // direct starts with a random map, then same-cycle priority
        map = 24'($urandom);
        wr(REG_SELECT_MAP, {8'h00, map});
        for (int i = 0; i < 6; i++) go(9'(1 << i), 2'h1, map[4*i +: 4]);
        go(9'h054, 2'h1, map[11:8]);
        // jog moves with the settings above
        for (int i = 0; i < 2; i++) begin
            go(i ? 9'h080 : 9'h0C0, 2'(i + 2), 4'h0);
            chk(32'(start_speed), jx[0]);
            chk(32'(start_accel), jx[1]);
            chk(32'(start_torque), jx[2]);
            chk(32'(start_travel), 32'(24'(i ? -jx[3] : jx[3])));
        end
        // preset accepted, then refused under alarm and under motion
        for (int i = 0; i < 3; i++) begin
            alarm_present <= (i == 1);
            motor_operating <= (i == 2);
            v = $urandom;
            if (i == 0) pv = v[23:0];
            wr(REG_PRESET, {{8{v[23]}}, v[23:0]});
            go(9'h100, 2'h0, 4'h0);
            chk(32'(command_position), 32'(pv));
        end
        alarm_present <= 1'b0;
        motor_operating <= 1'b0;
        // each mode: gated outputs, and no starts outside position control
        for (int i = 0; i < 8; i++) begin
            r = 5'($urandom);
            wr(REG_MODE, 32'(i % 4));
            {ready_raw, home_raw, end_raw, torque_reached_raw, torque_limiting_raw} <= r;
            repeat (2) @(posedge mclk);
            #1 chk(32'({ready_output, home_output, end_output, torque_limit_reached_output,
                        torque_limiting_output}), 32'(outx(r, 2'(i % 4))));
            if (i < 4 && i % 2 == 0) go(9'h002 << i, 2'h0, 4'h0);
        end
        wr(REG_MODE, 32'h1);
        go(9'h001, 2'h1, map[3:0]);
        conclude();
    end
endmodule
